/* shared/elc_consts.svh */
`ifndef ELC_CONSTS_SVH
`define ELC_CONSTS_SVH
// Overview of operation
// - One 8-bit control register steers line interface
// - Top three bits choose transmit build-out
// - Depth bit: 0 gives 128, 1 gives 32
// - Path bit places attenuator receive or transmit
// - Disable bit removes attenuator from path
// - Oversample received signal 32 times per bit
// - Recovered clock drives receive clock normally
// - No marks on line means carrier loss
// - Watch alternate clock input for presence
// - Loss with alternate clock: use that clock
// - Loss without alternate: crystal or transmit clock
// - Attenuator on receive side restores duty cycle
// - Output clock is crystal divided by four
// - Pull crystal to track incoming line rate
// - Excess jitter: divide 3.5 or 4.5 instead
// - Odd division sets limit-trip status flag
`define ELC_CTRL_OFS 8'h18
`define ELC_INFO_OFS 8'h19
`define ELC_CTRL_RST 8'h00
`define ELC_BO_HI 7
`define ELC_BO_LO 5
`define ELC_EGL_BIT 4
`define ELC_PATH_BIT 3
`define ELC_DEPTH_BIT 2
`define ELC_DIS_BIT 1
`define ELC_TPD_BIT 0
`define ELC_TRIP_BIT 5
`define ELC_ALT_BIT 1
`define ELC_LOSS_BIT 0
`define ELC_SYS_HZ 125000000
`define ELC_SYS_PERIOD_NS 8
`define ELC_XTAL_HZ 8192000
`define ELC_PLL_MULT 4
`define ELC_OS_RATE 32
`define ELC_NCO_W 32
`define ELC_DIV_NORM 4'h8
`define ELC_DIV_FAST 4'h7
`define ELC_DIV_SLOW 4'h9
`define ELC_DEPTH_DEEP 128
`define ELC_DEPTH_SHALLOW 32
`define ELC_JTR_DEEP_UI 120
`define ELC_JTR_SHALLOW_UI 28
`define ELC_ALT_TIMEOUT_NS 2000
`define ELC_LOS_BITS 255
`define ELC_RCLK_HI 2'h2
`define ELC_PULL_PPM 200
`define ELC_PPM_SCALE 1000000
`endif

/* shared/elc_pkg.sv */
package elc_pkg;
  typedef enum logic [1:0] {ELC_SRC_RECOV, ELC_SRC_ALT, ELC_SRC_ATTEN, ELC_SRC_XTAL} elc_src_t;
  typedef struct packed {
    logic [7:0] ctrl;
    logic trip;
    logic [7:0] rdata;
    logic [1:0] rxp_s;
    logic [1:0] rxn_s;
    logic mark_d;
    logic [2:0] alt_s;
    logic [2:0] tx_s;
    logic [31:0] os_acc;
    logic [31:0] ja_acc;
    logic [4:0] phase;
    logic mark_seen;
    logic rec_bit;
    logic [1:0] rec_hi;
    logic [15:0] los_cnt;
    logic loss;
    logic [11:0] alt_cnt;
    logic alt_ok;
    logic [3:0] div_cnt;
    logic [3:0] div_sel;
    logic ja_clk;
    logic rd_d;
    elc_src_t src;
    logic rx_clk;
    logic rx_data;
    logic tx_pos;
    logic tx_neg;
    logic tx_polar;
    logic pull;
  } elc_top_st_t;
endpackage

/* shared/elc_ja_if.sv */
`timescale 1ns/1ps
interface elc_ja_if;
  logic wr_en;
  logic wr_bit;
  logic rd_en;
  logic shallow;
  logic clear;
  logic rd_bit;
  logic [7:0] level;
  modport ctrl(output wr_en, output wr_bit, output rd_en, output shallow, output clear,
               input rd_bit, input level);
  modport store(input wr_en, input wr_bit, input rd_en, input shallow, input clear,
                output rd_bit, output level);
endinterface

/* hw/elc_bitbuf.sv */
`timescale 1ns/1ps
`include "elc_consts.svh"
module elc_bitbuf
  import elc_pkg::*;
#(
  parameter int DEPTH = `ELC_DEPTH_DEEP
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  elc_ja_if.store ja
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] lvl;
    logic rd_bit;
  } elc_buf_t;
  localparam logic [AW-1:0] HALF_DEEP = AW'(DEPTH / 2);
  localparam logic [AW-1:0] HALF_SH = AW'(`ELC_DEPTH_SHALLOW / 2);
  // Power of two keeps the pointer wrap a plain mask
  if (DEPTH > `ELC_DEPTH_DEEP || DEPTH < `ELC_DEPTH_SHALLOW || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("elc_bitbuf: DEPTH must be a power of two from 32 to 128");
  end
  elc_buf_t st_reg;
  elc_buf_t st_next;
  logic [AW-1:0] mask;
  logic [AW:0] cap;
  logic wok;
  logic rok;
  assign mask = ja.shallow ? AW'(`ELC_DEPTH_SHALLOW - 1) : AW'(DEPTH - 1);
  assign cap = ja.shallow ? (AW + 1)'(`ELC_DEPTH_SHALLOW) : (AW + 1)'(DEPTH);
  assign wok = ja.wr_en && (st_reg.lvl < cap);
  assign rok = ja.rd_en && (st_reg.lvl != '0);
  // Restart centred so both jitter directions get equal room
  always_comb begin
    st_next = st_reg;
    if (ja.clear) begin
      st_next.wp = ja.shallow ? HALF_SH : HALF_DEEP;
      st_next.rp = '0;
      st_next.lvl = {1'b0, st_next.wp};
    end else begin
      if (wok) begin
        st_next.mem[st_reg.wp] = ja.wr_bit;
        st_next.wp = (st_reg.wp + AW'(1)) & mask;
      end
      if (rok) begin
        st_next.rd_bit = st_reg.mem[st_reg.rp];
        st_next.rp = (st_reg.rp + AW'(1)) & mask;
      end
      st_next.lvl = st_reg.lvl + (AW + 1)'(wok) - (AW + 1)'(rok);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign ja.rd_bit = st_reg.rd_bit;
  assign ja.level = 8'(st_reg.lvl);
  a_level_cap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !ja.clear && ja.shallow |=> st_reg.lvl <= (AW + 1)'(`ELC_DEPTH_SHALLOW))
    else $error("buffer level above selected depth");
endmodule

/* hw/elc_top.sv */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "elc_consts.svh"
module elc_top
  import elc_pkg::*;
#(
  parameter int LOS_BITS = `ELC_LOS_BITS,
  parameter int ALT_TIMEOUT_NS = `ELC_ALT_TIMEOUT_NS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rx_line_pos,
  input wire logic i_rx_line_neg,
  input wire logic i_alt_clock_in,
  input wire logic i_tx_clock_in,
  input wire logic i_tx_data,
  output logic o_rx_clk,
  output logic o_rx_data,
  output logic o_rx_carrier_loss,
  output logic o_tx_line_pos,
  output logic o_tx_line_pos_oe,
  output logic o_tx_line_neg,
  output logic o_tx_line_neg_oe,
  output logic o_tx_power_down,
  output logic [2:0] o_buildout_sel,
  output logic o_eq_gain_limit,
  output logic o_xtal_load_low
);
  // Longest gap between alternate clock edges still counted as present
  localparam int ALT_CYC = (ALT_TIMEOUT_NS + `ELC_SYS_PERIOD_NS - 1) / `ELC_SYS_PERIOD_NS;
  localparam logic [11:0] ALT_LIM = 12'(ALT_CYC);
  localparam logic [15:0] LOS_LAST = 16'(LOS_BITS - 1);
  localparam logic [63:0] NCO_ONE = 64'h1 << `ELC_NCO_W;
  // Oversample rate: crystal times PLL factor, both edges used
  localparam logic [63:0] OS_INC64 =
    (NCO_ONE * 64'(`ELC_XTAL_HZ * `ELC_PLL_MULT * 2)) / 64'(`ELC_SYS_HZ);
  // Half-period ticks of the crystal allow the 3.5 division
  localparam logic [63:0] JA_INC64 = (NCO_ONE * 64'(`ELC_XTAL_HZ * 2)) / 64'(`ELC_SYS_HZ);
  localparam logic [31:0] OS_INC = OS_INC64[31:0];
  localparam logic [31:0] JA_INC = JA_INC64[31:0];
  localparam logic [31:0] JA_TRIM =
    32'((JA_INC64 * 64'(`ELC_PULL_PPM)) / 64'(`ELC_PPM_SCALE));
  localparam logic [4:0] OS_MID = 5'(`ELC_OS_RATE / 2 - 1);
  localparam logic [7:0] DP_CTR = 8'(`ELC_DEPTH_DEEP / 2);
  localparam logic [7:0] SH_CTR = 8'(`ELC_DEPTH_SHALLOW / 2);
  localparam logic [7:0] DP_HI = 8'(`ELC_DEPTH_DEEP / 2 + `ELC_JTR_DEEP_UI / 2);
  localparam logic [7:0] DP_LO = 8'(`ELC_DEPTH_DEEP / 2 - `ELC_JTR_DEEP_UI / 2);
  localparam logic [7:0] SH_HI = 8'(`ELC_DEPTH_SHALLOW / 2 + `ELC_JTR_SHALLOW_UI / 2);
  localparam logic [7:0] SH_LO = 8'(`ELC_DEPTH_SHALLOW / 2 - `ELC_JTR_SHALLOW_UI / 2);
  localparam elc_top_st_t ST_RST = '{
    ctrl: `ELC_CTRL_RST,
    div_sel: `ELC_DIV_NORM,
    src: ELC_SRC_RECOV,
    default: '0
  };

  // Counters are 16 and 12 bits wide
  if (LOS_BITS < 1 || LOS_BITS > 65535 || ALT_CYC < 2 || ALT_CYC > 4095) begin : g_chk
    $error("elc_top: LOS_BITS or ALT_TIMEOUT_NS out of range");
  end

  // Address match used by write and read decode
  function automatic logic f_hit(input logic [7:0] addr, input logic [7:0] ofs);
    f_hit = (addr == ofs);
  endfunction

  elc_top_st_t st_reg;
  elc_top_st_t st_next;
  elc_src_t src_next;
  logic [32:0] os_sum;
  logic [32:0] ja_sum;
  logic [31:0] ja_inc;
  logic os_tick;
  logic ja_tick;
  logic ja_on;
  logic rx_side;
  logic tx_side;
  logic mark;
  logic mark_rise;
  logic alt_rise;
  logic tx_rise;
  logic strobe;
  logic ja_wrap;
  logic lvl_hi;
  logic lvl_lo;
  logic [3:0] new_div;
  logic tx_ev;
  logic tx_bit;
  logic ctrl_wr;

  elc_ja_if ja();

  elc_bitbuf #(
    .DEPTH(`ELC_DEPTH_DEEP)
  ) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .ja(ja)
  );

  // Mode decode from the control register
  assign ctrl_wr = i_wr && f_hit(i_addr, `ELC_CTRL_OFS);
  assign ja_on = !st_reg.ctrl[`ELC_DIS_BIT];
  assign rx_side = ja_on && !st_reg.ctrl[`ELC_PATH_BIT];
  assign tx_side = ja_on && st_reg.ctrl[`ELC_PATH_BIT];

  // Edges only from the second and third synchroniser stages
  assign mark = st_reg.rxp_s[1] | st_reg.rxn_s[1];
  assign mark_rise = mark && !st_reg.mark_d;
  assign alt_rise = st_reg.alt_s[1] && !st_reg.alt_s[2];
  assign tx_rise = st_reg.tx_s[1] && !st_reg.tx_s[2];

  assign os_sum = {1'b0, st_reg.os_acc} + {1'b0, OS_INC};
  assign os_tick = os_sum[32];
  assign strobe = os_tick && !mark_rise && (st_reg.phase == OS_MID);

  // crystal pulled by trimming its rate
  always_comb begin
    if (st_reg.src == ELC_SRC_XTAL) begin
      ja_inc = JA_INC;
    end else if (st_reg.pull) begin
      ja_inc = JA_INC + JA_TRIM;
    end else begin
      ja_inc = JA_INC - JA_TRIM;
    end
  end
  assign ja_sum = {1'b0, st_reg.ja_acc} + {1'b0, ja_inc};
  assign ja_tick = ja_sum[32];
  assign ja_wrap = ja_tick && (st_reg.div_cnt == st_reg.div_sel - 4'h1);

  assign lvl_hi = ja.level > (ja.shallow ? SH_HI : DP_HI);
  assign lvl_lo = ja.level < (ja.shallow ? SH_LO : DP_LO);
  always_comb begin
    if (st_reg.src == ELC_SRC_XTAL || !ja_on) begin
      new_div = `ELC_DIV_NORM;
    end else if (lvl_hi) begin
      new_div = `ELC_DIV_FAST;
    end else if (lvl_lo) begin
      new_div = `ELC_DIV_SLOW;
    end else begin
      new_div = `ELC_DIV_NORM;
    end
  end

  // Buffer feed: recovered bits, alternate clock, or transmit clock
  always_comb begin
    if (rx_side) begin
      ja.wr_en = st_reg.loss ? (st_reg.alt_ok && alt_rise) : strobe;
      ja.wr_bit = !st_reg.loss && st_reg.mark_seen;
    end else begin
      ja.wr_en = tx_side && tx_rise;
      ja.wr_bit = i_tx_data;
    end
  end
  assign ja.rd_en = ja_wrap && ja_on;
  // depth bit to buffer; a write recentres at its new depth
  assign ja.shallow = ctrl_wr ? i_wdata[`ELC_DEPTH_BIT] : st_reg.ctrl[`ELC_DEPTH_BIT];
  // Mode change recentres; stale bits would otherwise leak out
  assign ja.clear = !ja_on || ctrl_wr || (st_reg.src == ELC_SRC_XTAL);

  // Transmit bits come from the buffer or straight from the framer
  assign tx_ev = tx_side ? st_reg.rd_d : tx_rise;
  assign tx_bit = tx_side ? ja.rd_bit : i_tx_data;

  // Receive clock source selection
  always_comb begin
    if (!st_reg.loss) begin
      src_next = rx_side ? ELC_SRC_ATTEN : ELC_SRC_RECOV;
    end else if (st_reg.alt_ok) begin
      src_next = rx_side ? ELC_SRC_ATTEN : ELC_SRC_ALT;
    end else begin
      src_next = tx_side ? ELC_SRC_ATTEN : ELC_SRC_XTAL;
    end
  end

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    if (ctrl_wr) begin
      st_next.ctrl = i_wdata;
    end
    // Read data valid only in the cycle after the strobe
    st_next.rdata = 8'h00;
    if (i_rd && f_hit(i_addr, `ELC_CTRL_OFS)) begin
      st_next.rdata = st_reg.ctrl;
    end else if (i_rd && f_hit(i_addr, `ELC_INFO_OFS)) begin
      st_next.rdata[`ELC_TRIP_BIT] = st_reg.trip;
      st_next.rdata[`ELC_ALT_BIT] = st_reg.alt_ok;
      st_next.rdata[`ELC_LOSS_BIT] = st_reg.loss;
      st_next.trip = 1'b0;
    end
    if (ja_wrap && new_div != `ELC_DIV_NORM) begin
      st_next.trip = 1'b1;
    end
    // Two-stage synchronisers for the line pair, three stages for the clock pins
    st_next.rxp_s = {st_reg.rxp_s[0], i_rx_line_pos};
    st_next.rxn_s = {st_reg.rxn_s[0], i_rx_line_neg};
    st_next.mark_d = mark;
    st_next.alt_s = {st_reg.alt_s[1:0], i_alt_clock_in};
    st_next.tx_s = {st_reg.tx_s[1:0], i_tx_clock_in};
    st_next.os_acc = os_sum[31:0];
    st_next.ja_acc = ja_sum[31:0];
    if (mark_rise) begin
      st_next.phase = 5'h00;
      st_next.mark_seen = 1'b1;
    end else if (os_tick) begin
      st_next.phase = st_reg.phase + 5'h01;
    end
    if (strobe) begin
      st_next.rec_bit = st_reg.mark_seen;
      st_next.mark_seen = 1'b0;
      st_next.rec_hi = `ELC_RCLK_HI;
      if (st_reg.mark_seen) begin
        st_next.los_cnt = 16'h0000;
        st_next.loss = 1'b0;
      end else if (st_reg.los_cnt == LOS_LAST) begin
        st_next.loss = 1'b1;
      end else begin
        st_next.los_cnt = st_reg.los_cnt + 16'h0001;
      end
    end else if (st_reg.rec_hi != 2'h0) begin
      st_next.rec_hi = st_reg.rec_hi - 2'h1;
    end
    if (alt_rise) begin
      st_next.alt_cnt = 12'h000;
    end else if (st_reg.alt_cnt != ALT_LIM) begin
      st_next.alt_cnt = st_reg.alt_cnt + 12'h001;
    end
    st_next.alt_ok = (st_reg.alt_cnt != ALT_LIM);
    // crystal divider, ratio picked per period
    if (ja_wrap) begin
      st_next.div_cnt = 4'h0;
      st_next.div_sel = new_div;
    end else if (ja_tick) begin
      st_next.div_cnt = st_reg.div_cnt + 4'h1;
    end
    st_next.ja_clk = st_reg.div_cnt < (st_reg.div_sel >> 1);
    st_next.rd_d = ja.rd_en;
    // fill above centre speeds the crystal
    st_next.pull = ja.level > (ja.shallow ? SH_CTR : DP_CTR);
    st_next.src = src_next;
    // Receive clock and data mux
    case (st_reg.src)
      ELC_SRC_RECOV: begin
        st_next.rx_clk = (st_reg.rec_hi != 2'h0);
        st_next.rx_data = st_reg.rec_bit;
      end
      ELC_SRC_ALT: begin
        st_next.rx_clk = st_reg.alt_s[2];
        st_next.rx_data = 1'b0;
      end
      ELC_SRC_ATTEN: begin
        st_next.rx_clk = st_reg.ja_clk;
        st_next.rx_data = rx_side && ja.rd_bit;
      end
      ELC_SRC_XTAL: begin
        st_next.rx_clk = st_reg.ja_clk;
        st_next.rx_data = 1'b0;
      end
      default: begin
        st_next.rx_clk = 1'b0;
        st_next.rx_data = 1'b0;
      end
    endcase
    // Alternate mark inversion on the transmit pair
    if (tx_ev) begin
      if (tx_bit) begin
        st_next.tx_pos = !st_reg.tx_polar;
        st_next.tx_neg = st_reg.tx_polar;
        st_next.tx_polar = !st_reg.tx_polar;
      end else begin
        st_next.tx_pos = 1'b0;
        st_next.tx_neg = 1'b0;
      end
    end
    if (st_reg.ctrl[`ELC_TPD_BIT]) begin
      st_next.tx_pos = 1'b0;
      st_next.tx_neg = 1'b0;
    end
  end

  // Single state register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata = st_reg.rdata;
  assign o_rx_clk = st_reg.rx_clk;
  assign o_rx_data = st_reg.rx_data;
  assign o_rx_carrier_loss = st_reg.loss;
  assign o_tx_line_pos = st_reg.tx_pos;
  assign o_tx_line_neg = st_reg.tx_neg;
  assign o_tx_line_pos_oe = !st_reg.ctrl[`ELC_TPD_BIT];
  assign o_tx_line_neg_oe = !st_reg.ctrl[`ELC_TPD_BIT];
  assign o_tx_power_down = st_reg.ctrl[`ELC_TPD_BIT];
  assign o_buildout_sel = st_reg.ctrl[`ELC_BO_HI:`ELC_BO_LO];
  assign o_eq_gain_limit = st_reg.ctrl[`ELC_EGL_BIT];
  assign o_xtal_load_low = st_reg.pull;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_ctrl_write: assert property (
    ctrl_wr |=> st_reg.ctrl == $past(i_wdata))
    else $error("control write not stored");
  a_buildout_out: assert property (
    ctrl_wr |=> o_buildout_sel == $past(i_wdata[`ELC_BO_HI:`ELC_BO_LO]))
    else $error("build-out select not driven");
  a_eq_limit: assert property (
    ctrl_wr |=> o_eq_gain_limit == $past(i_wdata[`ELC_EGL_BIT]))
    else $error("gain limit not driven");
  a_tx_tristate: assert property (
    st_reg.ctrl[`ELC_TPD_BIT] && $past(st_reg.ctrl[`ELC_TPD_BIT]) |->
      !o_tx_line_pos_oe && !o_tx_line_neg_oe && !o_tx_line_pos && !o_tx_line_neg)
    else $error("transmitter not powered down");
  a_no_write_dis: assert property (
    st_reg.ctrl[`ELC_DIS_BIT] |-> !ja.wr_en && ja.clear)
    else $error("disabled attenuator still fed");
  a_div_legal: assert property (
    st_reg.div_sel inside {`ELC_DIV_FAST, `ELC_DIV_NORM, `ELC_DIV_SLOW})
    else $error("illegal crystal division");
  a_trip_set: assert property (
    ja_wrap && new_div != `ELC_DIV_NORM |=> st_reg.trip)
    else $error("limit trip flag not set");
  a_loss_set: assert property (
    strobe && !st_reg.mark_seen && st_reg.los_cnt == LOS_LAST |=> o_rx_carrier_loss)
    else $error("carrier loss not declared");
  a_alt_src: assert property (
    st_reg.loss && st_reg.alt_ok && tx_side |=> st_reg.src == ELC_SRC_ALT)
    else $error("alternate clock not selected");
  a_xtal_src: assert property (
    st_reg.loss && !st_reg.alt_ok && rx_side |=> st_reg.src == ELC_SRC_XTAL)
    else $error("crystal not selected on loss");
  a_recov_src: assert property (
    !st_reg.loss && !ja_on |=> st_reg.src == ELC_SRC_RECOV)
    else $error("recovered clock not selected");
  a_alt_timeout: assert property (
    st_reg.alt_cnt == ALT_LIM && !alt_rise |=> !st_reg.alt_ok)
    else $error("absent alternate clock seen as present");

  c_loss: cover property (!o_rx_carrier_loss ##1 o_rx_carrier_loss);
  c_trip: cover property (ja_wrap && new_div == `ELC_DIV_FAST);
  c_alt: cover property (st_reg.src == ELC_SRC_ALT);
  c_tx_mark: cover property (tx_ev && tx_bit && tx_side);
endmodule

/* sim/elc_line_model.sv */
`timescale 1ns/1ps
module elc_line_model (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_line_on,
  input wire logic i_alt_on,
  input wire logic [7:0] i_bit_cyc,
  output logic o_rx_pos,
  output logic o_rx_neg,
  output logic o_alt_clk,
  output logic o_tx_clk
);
  logic [7:0] bit_reg;
  logic [7:0] alt_reg;
  logic [7:0] tx_reg;
  logic pol_reg;
  // Bit timer of the far end, alternate clock of 80 cycles, transmit clock of 61
  always @(posedge i_clk_sys) begin
    bit_reg <= (!i_rst_n || bit_reg >= i_bit_cyc - 8'h01) ? 8'h00 : bit_reg + 8'h01;
    alt_reg <= (!i_rst_n || alt_reg == 8'h4F) ? 8'h00 : alt_reg + 8'h01;
    tx_reg <= (!i_rst_n || tx_reg == 8'h3C) ? 8'h00 : tx_reg + 8'h01;
    pol_reg <= !i_rst_n ? 1'b0 : pol_reg ^ (bit_reg == 8'h00);
  end
  // All-ones AMI, half-bit marks; a cut line shows no marks at all
  assign o_rx_pos = i_line_on && pol_reg && (bit_reg < (i_bit_cyc >> 1));
  assign o_rx_neg = i_line_on && !pol_reg && (bit_reg < (i_bit_cyc >> 1));
  // Absent alternate clock is tied low, so nothing can be sensed falsely
  assign o_alt_clk = i_alt_on && (alt_reg < 8'h28);
  assign o_tx_clk = tx_reg < 8'h1E;
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "elc_consts.svh"
module testbench;
  typedef struct {logic [7:0] wd; logic [2:0] bo; logic eq_gain_limit; logic tx_power_down;} tb_row_t;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, line_on = 1, alt_on = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, bit_cyc = 8'h3D, d;
  logic [7:0] rdata;
  logic rxp, rxn, alt, txc, rx_clk, rx_data, loss, txp, txpoe, txn, txnoe, tx_power_down, eq_gain_limit, xll;
  logic [2:0] bo;
  int err_count = 0, checks_done = 0, i, n, hi, per;
  tb_row_t rows [5] = '{'{8'hE0, 3'h7, 1'b0, 1'b0}, '{8'h10, 3'h0, 1'b1, 1'b0},
    '{8'h01, 3'h0, 1'b0, 1'b1}, '{8'hA5, 3'h5, 1'b0, 1'b1}, '{8'h4A, 3'h2, 1'b0, 1'b0}};
  // 125 MHz system clock
  always #4 clk = ~clk;
  elc_top #(.LOS_BITS(8), .ALT_TIMEOUT_NS(800)) i_elc_top (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_rx_line_pos(rxp), .i_rx_line_neg(rxn), .i_alt_clock_in(alt), .i_tx_clock_in(txc),
    .i_tx_data(1'b1), .o_rx_clk(rx_clk), .o_rx_data(rx_data), .o_rx_carrier_loss(loss),
    .o_tx_line_pos(txp), .o_tx_line_pos_oe(txpoe), .o_tx_line_neg(txn),
    .o_tx_line_neg_oe(txnoe), .o_tx_power_down(tx_power_down), .o_buildout_sel(bo),
    .o_eq_gain_limit(eq_gain_limit), .o_xtal_load_low(xll));
  elc_line_model i_elc_line_model (.i_clk_sys(clk), .i_rst_n(rst_n), .i_line_on(line_on),
    .i_alt_on(alt_on), .i_bit_cyc(bit_cyc), .o_rx_pos(rxp), .o_rx_neg(rxn),
    .o_alt_clk(alt), .o_tx_clk(txc));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %h want %h", $time, msg, seen, exp);
    end
  endtask
  // One nanosecond past the edge, so outputs have settled
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // High time and period of the receive clock, second pulse taken
  task automatic measure(input int settle);
    repeat (settle) tick;
    repeat (2) begin
      n = 0;
      while (rx_clk !== 1'b0 && n < 300) begin tick; n++; end
      while (rx_clk !== 1'b1 && n < 600) begin tick; n++; end
    end
    hi = 0;
    per = 0;
    while (rx_clk === 1'b1 && hi < 200) begin tick; hi++; end
    per = hi;
    while (rx_clk === 1'b0 && per < 300) begin tick; per++; end
  endtask
  function automatic logic [7:0] duty(input int p, input int tol);
    return {7'h0, per >= p - tol && per <= p + tol && 2 * hi >= per - 8 && 2 * hi <= per + 8};
  endfunction
  function automatic logic [7:0] short_hi();
    return {7'h0, hi >= 1 && hi <= 4 && per >= 57 && per <= 65};
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog at 40k cycles, well beyond the expected 11k or so
  initial begin
    #320000;
    err_count++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick;
    check(rdata, 8'h00, "idle read data");
    check({6'h0, txpoe, txnoe}, 8'h03, "drivers on after reset");
    rd_reg(`ELC_CTRL_OFS, d);
    check(d, `ELC_CTRL_RST, "control reset value");
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      wr_reg(`ELC_CTRL_OFS, rows[i].wd);
      rd_reg(`ELC_CTRL_OFS, d);
      check(d, rows[i].wd, "control readback");
      check({5'h0, bo}, {5'h0, rows[i].bo}, "build-out select");
      check({7'h0, eq_gain_limit}, {7'h0, rows[i].eq_gain_limit}, "gain limit");
      check({5'h0, tx_power_down, txpoe, txnoe}, {5'h0, rows[i].tx_power_down, ~rows[i].tx_power_down, ~rows[i].tx_power_down},
        "power-down");
      check({6'h0, txp, txn} & {8{rows[i].tx_power_down}}, 8'h00, "power-down silences pair");
    end
    wr_reg(8'h17, 8'hFF);
    rd_reg(`ELC_CTRL_OFS, d);
    check(d, 8'h4A, "unmapped write ignored");
    rd_reg(8'h1A, d);
    check(d, 8'h00, "unmapped read");
    $display("test registers done");
    wr_reg(`ELC_CTRL_OFS, 8'h00);
    measure(400);
    check(duty(61, 4), 8'h01, "attenuated clock near half duty");
    // Powered transmitter: marks on both wires, never together
    n = 0;
    i = 0;
    repeat (200) begin
      tick;
      if (txp === 1'b1) n++;
      if (txn === 1'b1) i++;
      check({7'h0, txp & txn}, 8'h00, "transmit pair both marked");
    end
    check({7'h0, (n > 0 && i > 0)}, 8'h01, "transmit marks on both wires");
    wr_reg(`ELC_CTRL_OFS, 8'h02);
    measure(100);
    check(short_hi(), 8'h01, "disabled gives recovered pulses");
    check({7'h0, rx_data}, 8'h01, "recovered all-ones data");
    wr_reg(`ELC_CTRL_OFS, 8'h08);
    measure(100);
    check(short_hi(), 8'h01, "transmit-side gives recovered pulses");
    $display("test clock paths done");
    // Fast far end: shallow buffer trips long before the deep one
    bit_cyc <= 8'h2D;
    wr_reg(`ELC_CTRL_OFS, 8'h00);
    rd_reg(`ELC_INFO_OFS, d);
    repeat (4000) tick;
    rd_reg(`ELC_INFO_OFS, d);
    check(d & 8'h20, 8'h00, "deep buffer not tripped");
    // Low delay chosen over wander margin
    wr_reg(`ELC_CTRL_OFS, 8'h04);
    rd_reg(`ELC_INFO_OFS, d);
    repeat (4000) tick;
    check({7'h0, xll}, 8'h01, "crystal pulled faster");
    rd_reg(`ELC_INFO_OFS, d);
    check(d & 8'h20, 8'h20, "shallow buffer trip flag");
    bit_cyc <= 8'h3D;
    wr_reg(`ELC_CTRL_OFS, 8'h00);
    $display("test limit trip done");
    line_on <= 1'b0;
    n = 0;
    while (loss !== 1'b1 && n < 1200) begin tick; n++; end
    check({7'h0, loss}, 8'h01, "carrier loss declared");
    rd_reg(`ELC_INFO_OFS, d);
    check(d & 8'h03, 8'h01, "info shows loss, no alternate");
    measure(50);
    check(duty(61, 4), 8'h01, "centred crystal");
    check({7'h0, rx_data}, 8'h00, "no data from crystal");
    wr_reg(`ELC_CTRL_OFS, 8'h08);
    measure(50);
    check(duty(61, 4), 8'h01, "transmit clock through attenuator");
    alt_on <= 1'b1;
    repeat (100) tick;
    rd_reg(`ELC_INFO_OFS, d);
    check(d & 8'h03, 8'h03, "alternate clock sensed");
    measure(20);
    check(duty(80, 4), 8'h01, "alternate clock direct");
    wr_reg(`ELC_CTRL_OFS, 8'h00);
    measure(400);
    check(duty(61, 10), 8'h01, "alternate clock through attenuator");
    alt_on <= 1'b0;
    repeat (150) tick;
    rd_reg(`ELC_INFO_OFS, d);
    check(d & 8'h03, 8'h01, "alternate clock gone");
    line_on <= 1'b1;
    n = 0;
    while (loss !== 1'b0 && n < 300) begin tick; n++; end
    check({7'h0, loss}, 8'h00, "carrier restored");
    rd_reg(`ELC_INFO_OFS, d);
    check(d & 8'h03, 8'h00, "info shows carrier");
    $display("test carrier loss done");
    // Reset in mid-run must drop a programmed control value
    wr_reg(`ELC_CTRL_OFS, 8'hE5);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`ELC_CTRL_OFS, d);
    check(d, `ELC_CTRL_RST, "control cleared by reset");
    check({6'h0, txpoe, txnoe}, 8'h03, "drivers on after second reset");
    $display("test mid-run reset done");
    tally_and_finish;
  end
endmodule
